// File: design/xcc_consts.svh
`ifndef XCC_CONSTS_SVH
`define XCC_CONSTS_SVH

`define XCC_OFF_MAKER_ID     12'h000
`define XCC_OFF_ERR_HDR      12'h100
`define XCC_OFF_VC_HDR       12'h140
`define XCC_OFF_VC_CAP1      12'h144
`define XCC_OFF_VC_CAP2      12'h148
`define XCC_OFF_VC_CTLSTS    12'h14c
`define XCC_OFF_CHANNEL_ZERO_RCAP 12'h150
`define XCC_OFF_CHANNEL_ZERO_RCTL 12'h154
`define XCC_OFF_CHANNEL_ZERO_RSTS 12'h158
`define XCC_OFF_VC1_RCAP     12'h15c
`define XCC_OFF_VC1_RCTL     12'h160
`define XCC_OFF_VC1_RSTS     12'h164
`define XCC_OFF_ARB_BASE     12'h180
`define XCC_OFF_ARB_LAST     12'h1bc
`define XCC_OFF_PWR_HDR      12'h20c
`define XCC_OFF_ACS_HDR      12'h220
`define XCC_OFF_ACS_CAPCTL   12'h224
`define XCC_OFF_EGRESS       12'h228
`define XCC_OFF_LTR_HDR      12'h230
`define XCC_OFF_LTR_LIMITS   12'h234

`define XCC_ID_ERR           16'h0001
`define XCC_ID_VC            16'h0002
`define XCC_ID_PWR           16'h0004
`define XCC_ID_ACS           16'h000d
`define XCC_ID_LTR           16'h0018
`define XCC_CAP_VERSION      4'h1
`define XCC_NEXT_END         12'h000

`define XCC_VC_EXT_COUNT     32'h00000001
`define XCC_VC_ARB_OFF       32'h03000000
`define XCC_CHANNEL_ZERO_RCAP_VAL 32'h04000000
`define XCC_VC1_RCAP_VAL     32'h06000000

`define XCC_VCCTL_MASK       32'h0000000e
`define XCC_RCTL_MASK        32'h870000ff
`define XCC_CHANNEL_ZERO_RCTL_RST 32'h800000ff
`define XCC_VC1_RCTL_RST     32'h00000000
`define XCC_ACSCTL_MASK      32'h007f0000
`define XCC_EGRESS_MASK      32'h000000ff
`define XCC_LTR_MASK         32'h1fff1fff
`define XCC_LTR_RST          32'h00000000

`define XCC_MAKER_ID_RST     16'h1b2c // Arbitrary value
`define XCC_DEVICE_ID        16'h0001 // Arbitrary value
`define XCC_ARB_WORDS        16

`endif

// File: design/xcc_pkg.sv
`include "xcc_consts.svh"
package xcc_pkg;
   typedef logic [11:0] xcc_addr_t;
   typedef logic [3:0]  xcc_arb_idx_t;

   typedef struct packed {
      logic [`XCC_ARB_WORDS-1:0][31:0] word;
   } xcc_tbl_state_t;

   typedef struct packed {
      logic [31:0] rdata;
      logic        ack;
      logic [15:0] maker_id;
      logic        strap_done;
      logic        acs_fitted;
      logic [31:0] vc_ctl;
      logic [31:0] channel_zero_rctl;
      logic [31:0] vc1_rctl;
      logic [31:0] acs_ctl;
      logic [31:0] egress;
      logic [31:0] ltr;
   } xcc_state_t;
endpackage

// File: design/xcc_tbl_if.sv
`timescale 1ns/1ps
interface xcc_tbl_if;
   logic [3:0]  idx;
   logic        wr;
   logic [31:0] wdata;
   logic [3:0]  be;
   logic [31:0] rdata;

   modport ctrl (output idx, output wr, output wdata, output be, input rdata);
   modport tbl  (input idx, input wr, input wdata, input be, output rdata);
endinterface

// File: design/xcc_arb_table.sv
`timescale 1ns/1ps
`include "xcc_consts.svh"
module xcc_arb_table (
   // Clock and reset
   input  wire logic clk_sys_i,
   input  wire logic resetn_i,
   // Table port
   xcc_tbl_if.tbl    tbl_io
);
   import xcc_pkg::*;

   xcc_tbl_state_t state_ff;
   xcc_tbl_state_t nxt_state;

   // 128 phases of 4 bits, 8 phases per dword
   always_comb begin
      nxt_state = state_ff;
      if (tbl_io.wr) begin
         for (int b = 0; b < 4; b++) begin
            if (tbl_io.be[b]) begin
               nxt_state.word[tbl_io.idx][b*8 +: 8] = tbl_io.wdata[b*8 +: 8];
            end
         end
      end
   end

   assign tbl_io.rdata = state_ff.word[tbl_io.idx];

   always_ff @(posedge clk_sys_i or negedge resetn_i) begin
      if (!resetn_i) begin
         state_ff <= '0;
      end else begin
         state_ff <= nxt_state;
      end
   end
endmodule

// File: design/xcc_ext_config.sv
`timescale 1ns/1ps
`include "xcc_consts.svh"
module xcc_ext_config (
   // Clock and reset
   input  wire logic              clk_sys_i,
   input  wire logic              resetn_i,
   // Strap: access control capability fitted
   input  wire logic              acs_present_i,
   // Configuration access
   input  wire logic              cfg_req_i,
   input  wire logic              cfg_we_i,
   input  wire xcc_pkg::xcc_addr_t cfg_addr_i,
   input  wire logic [3:0]        cfg_be_i,
   input  wire logic [31:0]       cfg_wdata_i,
   output logic [31:0]            cfg_rdata_o,
   output logic                   cfg_ack_o,
   // Identifier load from SMBus or EEPROM
   input  wire logic              id_load_i,
   input  wire logic [15:0]       id_load_data_i
);
   import xcc_pkg::*;

   xcc_state_t state_ff;
   xcc_state_t nxt_state;
   xcc_tbl_if  tbl_bus ();

   function automatic logic hit(input xcc_addr_t a, input logic [11:0] off);
      hit = (a[11:2] == off[11:2]);
   endfunction

   function automatic logic [31:0] hdr(input logic [11:0] nxt, input logic [15:0] id);
      hdr = {nxt, `XCC_CAP_VERSION, id};
   endfunction

   function automatic logic [31:0] lane_mask(input logic [3:0] be);
      lane_mask = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
   endfunction

   function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] wd,
                                         input logic [3:0] be, input logic [31:0] mask);
      logic [31:0] bmask;
      bmask = lane_mask(be) & mask;
      merge = (old & ~bmask) | (wd & bmask);
   endfunction

   function automatic xcc_addr_t dw_addr(input xcc_addr_t a);
      dw_addr = {a[11:2], 2'b00};
   endfunction

   function automatic logic is_arb(input xcc_addr_t a);
      is_arb = (a >= `XCC_OFF_ARB_BASE) && (a <= `XCC_OFF_ARB_LAST);
   endfunction

   function automatic logic [11:0] pwr_next_ptr(input logic fitted);
      pwr_next_ptr = fitted ? `XCC_OFF_ACS_HDR : `XCC_OFF_LTR_HDR;
   endfunction

   function automatic logic [31:0] acs_hdr_word(input logic fitted);
      acs_hdr_word = fitted ? hdr(`XCC_NEXT_END, `XCC_ID_ACS) : 32'h0000_0000;
   endfunction

   // Decode and strobe signals
   logic        arb_hit;
   logic        rd_en;
   logic        wr_en;
   xcc_addr_t   addr_dw;
   logic [31:0] rd_val;
   logic        fx_hit;
   logic [31:0] fx_val;
   logic [31:0] st_val;
   logic        we_vc_ctl;
   logic        we_ch_zero_rctl;
   logic        we_vc1_rctl;
   logic        we_acs_ctl;
   logic        we_egress;
   logic        we_ltr;

   // Dword-aligned access address
   assign addr_dw = dw_addr(cfg_addr_i);
   assign rd_en   = cfg_req_i && !cfg_we_i;
   assign wr_en   = cfg_req_i && cfg_we_i;

   // Arbitration table window
   assign arb_hit = is_arb(addr_dw);

   // Arbitration table port
   assign tbl_bus.idx   = cfg_addr_i[5:2];
   assign tbl_bus.wr    = wr_en && arb_hit;
   assign tbl_bus.wdata = cfg_wdata_i;
   assign tbl_bus.be    = cfg_be_i;

   xcc_arb_table u_arb_table (
      .clk_sys_i (clk_sys_i),
      .resetn_i  (resetn_i),
      .tbl_io    (tbl_bus.tbl)
   );

   // Map of the extended space
   // 000h maker identifier, read-only
   // 100h error report header, first extended capability
   // 140h channel header
   // 144h-148h port channel capabilities
   // 14Ch port channel control and status
   // 150h-158h channel zero resource set
   // 15Ch-164h channel one resource set
   // 180h-1BCh channel zero arbitration table
   // 20Ch power budget header
   // 220h-228h access control, when fitted
   // 230h latency report header
   // 234h latency limits
   // Anything else reads zero

   // Fixed header and capability words
   always_comb begin
      fx_hit = 1'b1;
      fx_val = 32'h0000_0000;
      case (addr_dw)
         `XCC_OFF_ERR_HDR: begin
            fx_val = hdr(`XCC_OFF_VC_HDR, `XCC_ID_ERR);
         end
         `XCC_OFF_VC_HDR: begin
            fx_val = hdr(`XCC_OFF_PWR_HDR, `XCC_ID_VC);
         end
         `XCC_OFF_VC_CAP1: begin
            fx_val = `XCC_VC_EXT_COUNT;
         end
         `XCC_OFF_VC_CAP2: begin
            fx_val = `XCC_VC_ARB_OFF;
         end
         `XCC_OFF_CHANNEL_ZERO_RCAP: begin
            fx_val = `XCC_CHANNEL_ZERO_RCAP_VAL;
         end
         `XCC_OFF_VC1_RCAP: begin
            fx_val = `XCC_VC1_RCAP_VAL;
         end
         `XCC_OFF_PWR_HDR: begin
            fx_val = hdr(pwr_next_ptr(state_ff.acs_fitted), `XCC_ID_PWR);
         end
         `XCC_OFF_ACS_HDR: begin
            fx_val = acs_hdr_word(state_ff.acs_fitted);
         end
         `XCC_OFF_LTR_HDR: begin
            fx_val = hdr(`XCC_NEXT_END, `XCC_ID_LTR);
         end
         default: begin
            fx_hit = 1'b0;
         end
      endcase
   end

   // Register-held words
   always_comb begin
      st_val = 32'h0000_0000;
      case (addr_dw)
         `XCC_OFF_MAKER_ID: begin
            st_val = {`XCC_DEVICE_ID, state_ff.maker_id};
         end
         `XCC_OFF_VC_CTLSTS: begin
            st_val = state_ff.vc_ctl;
         end
         `XCC_OFF_CHANNEL_ZERO_RCTL: begin
            st_val = state_ff.channel_zero_rctl;
         end
         `XCC_OFF_CHANNEL_ZERO_RSTS: begin
            st_val = 32'h0000_0000;
         end
         `XCC_OFF_VC1_RCTL: begin
            st_val = state_ff.vc1_rctl;
         end
         `XCC_OFF_VC1_RSTS: begin
            st_val = 32'h0000_0000;
         end
         `XCC_OFF_ACS_CAPCTL: begin
            st_val = state_ff.acs_ctl;
         end
         `XCC_OFF_EGRESS: begin
            st_val = state_ff.egress;
         end
         `XCC_OFF_LTR_LIMITS: begin
            st_val = state_ff.ltr;
         end
         default: begin
            st_val = 32'h0000_0000;
         end
      endcase
   end

   // Read word select
   always_comb begin
      if (arb_hit) begin
         rd_val = tbl_bus.rdata;
      end else if (fx_hit) begin
         rd_val = fx_val;
      end else begin
         rd_val = st_val;
      end
   end

   // Write strobe decode
   always_comb begin
      we_vc_ctl       = 1'b0;
      we_ch_zero_rctl = 1'b0;
      we_vc1_rctl     = 1'b0;
      we_acs_ctl      = 1'b0;
      we_egress       = 1'b0;
      we_ltr          = 1'b0;
      if (wr_en) begin
         case (addr_dw)
            `XCC_OFF_MAKER_ID: begin
               // Config writes never reach the identifier
            end
            `XCC_OFF_VC_CTLSTS: begin
               we_vc_ctl = 1'b1;
            end
            `XCC_OFF_CHANNEL_ZERO_RCTL: begin
               we_ch_zero_rctl = 1'b1;
            end
            `XCC_OFF_VC1_RCTL: begin
               we_vc1_rctl = 1'b1;
            end
            `XCC_OFF_ACS_CAPCTL: begin
               if (state_ff.acs_fitted) begin
                  we_acs_ctl = 1'b1;
               end
            end
            `XCC_OFF_EGRESS: begin
               if (state_ff.acs_fitted) begin
                  we_egress = 1'b1;
               end
            end
            `XCC_OFF_LTR_LIMITS: begin
               we_ltr = 1'b1;
            end
            default: begin
               // Read-only and unmapped offsets drop writes
            end
         endcase
      end
   end

   // Next state
   always_comb begin
      nxt_state     = state_ff;
      // Every request answered one cycle later
      nxt_state.ack = cfg_req_i;
      // Read data holds until the next read
      if (rd_en) begin
         nxt_state.rdata = rd_val;
      end
      // Strap captured once after reset
      if (!state_ff.strap_done) begin
         nxt_state.strap_done = 1'b1;
         nxt_state.acs_fitted = acs_present_i;
      end
      // Identifier load path
      if (id_load_i) begin
         nxt_state.maker_id = id_load_data_i;
      end
      // Writable control fields
      if (we_vc_ctl) begin
         nxt_state.vc_ctl = merge(state_ff.vc_ctl, cfg_wdata_i, cfg_be_i, `XCC_VCCTL_MASK);
      end
      if (we_ch_zero_rctl) begin
         nxt_state.channel_zero_rctl = merge(state_ff.channel_zero_rctl, cfg_wdata_i, cfg_be_i, `XCC_RCTL_MASK);
      end
      if (we_vc1_rctl) begin
         nxt_state.vc1_rctl = merge(state_ff.vc1_rctl, cfg_wdata_i, cfg_be_i, `XCC_RCTL_MASK);
      end
      if (we_acs_ctl) begin
         nxt_state.acs_ctl = merge(state_ff.acs_ctl, cfg_wdata_i, cfg_be_i, `XCC_ACSCTL_MASK);
      end
      if (we_egress) begin
         nxt_state.egress = merge(state_ff.egress, cfg_wdata_i, cfg_be_i, `XCC_EGRESS_MASK);
      end
      if (we_ltr) begin
         nxt_state.ltr = merge(state_ff.ltr, cfg_wdata_i, cfg_be_i, `XCC_LTR_MASK);
      end
   end

   always_ff @(posedge clk_sys_i or negedge resetn_i) begin
      if (!resetn_i) begin
         // Defaults while reset is low
         state_ff.rdata             <= 32'h0000_0000;
         state_ff.ack               <= 1'b0;
         state_ff.maker_id          <= `XCC_MAKER_ID_RST;
         state_ff.strap_done        <= 1'b0;
         state_ff.acs_fitted        <= 1'b0;
         state_ff.vc_ctl            <= 32'h0000_0000;
         state_ff.channel_zero_rctl <= `XCC_CHANNEL_ZERO_RCTL_RST;
         state_ff.vc1_rctl          <= `XCC_VC1_RCTL_RST;
         state_ff.acs_ctl           <= 32'h0000_0000;
         state_ff.egress            <= 32'h0000_0000;
         state_ff.ltr               <= `XCC_LTR_RST;
      end else begin
         state_ff <= nxt_state;
      end
   end

   // Outputs straight from flops
   assign cfg_rdata_o = state_ff.rdata;
   assign cfg_ack_o   = state_ff.ack;
endmodule

// File: dv/xcc_ext_checker.sv
`timescale 1ns/1ps
`include "xcc_consts.svh"
module xcc_ext_checker
   import xcc_pkg::*;
(
   // Clock and reset
   input wire logic        clk_sys_i,
   input wire logic        resetn_i,
   // Watched ports
   input wire logic        acs_present_i,
   input wire logic        cfg_req_i,
   input wire logic        cfg_we_i,
   input wire xcc_addr_t   cfg_addr_i,
   input wire logic [31:0] cfg_rdata_o,
   input wire logic        cfg_ack_o
);
   wire logic rd = cfg_req_i && !cfg_we_i;
   default clocking cb @(posedge clk_sys_i); endclocking
   default disable iff (!resetn_i);
   property p_rd(logic [11:0] a, logic [31:0] v);
      rd && cfg_addr_i[11:2] == a[11:2] |=> cfg_rdata_o == v;
   endproperty
   a_ack_after_req: assert property (cfg_req_i |=> cfg_ack_o) else $error("Ack missing");
   a_ack_needs_req: assert property (!cfg_req_i |=> !cfg_ack_o) else $error("Ack without request");
   a_rdata_holds: assert property (!rd |=> $stable(cfg_rdata_o)) else $error("Read data moved");
   a_err_header: assert property (p_rd(`XCC_OFF_ERR_HDR, 32'h14010001))
      else $error("Error header wrong");
   a_virtual_channel_cap_header: assert property (p_rd(`XCC_OFF_VC_HDR, 32'h20c10002))
      else $error("Channel header wrong");
   a_pwr_header: assert property (p_rd(`XCC_OFF_PWR_HDR, acs_present_i ? 32'h22010004 : 32'h23010004))
      else $error("Power header wrong");
   a_access_control_cap_header: assert property (p_rd(`XCC_OFF_ACS_HDR, acs_present_i ? 32'h0001000d : 32'h0))
      else $error("Access header wrong");
   a_vc1_rcap: assert property (p_rd(`XCC_OFF_VC1_RCAP, 32'h06000000))
      else $error("Channel one capability wrong");
   a_latency_report_cap_header: assert property (p_rd(`XCC_OFF_LTR_HDR, 32'h00010018))
      else $error("Latency header wrong");
   c_read: cover property (rd ##1 rd);
   c_write: cover property (cfg_req_i && cfg_we_i);
   c_no_acs: cover property (rd && !acs_present_i);
endmodule
bind xcc_ext_config xcc_ext_checker u_chk (.*);

// File: dv/tb.sv
`timescale 1ns/1ps
`include "xcc_consts.svh"
module tb;
   import xcc_pkg::*;
   logic        clk_sys_i = 0;
   logic        resetn_i = 0;
   logic        acs_present_i = 1;
   logic        cfg_req_i = 0;
   logic        cfg_we_i = 0;
   xcc_addr_t   cfg_addr_i = '0;
   logic [3:0]  cfg_be_i = '0;
   logic [31:0] cfg_wdata_i = '0;
   logic [31:0] cfg_rdata_o;
   logic        cfg_ack_o;
   logic        id_load_i = 0;
   logic [15:0] id_load_data_i = '0;
   int          num_errors = 0;
   int          n_compared = 0;
   int          cycles = 0;
   xcc_ext_config dut (.clk_sys_i(clk_sys_i), .resetn_i(resetn_i), .acs_present_i(acs_present_i),
      .cfg_req_i(cfg_req_i), .cfg_we_i(cfg_we_i), .cfg_addr_i(cfg_addr_i), .cfg_be_i(cfg_be_i),
      .cfg_wdata_i(cfg_wdata_i), .cfg_rdata_o(cfg_rdata_o), .cfg_ack_o(cfg_ack_o),
      .id_load_i(id_load_i), .id_load_data_i(id_load_data_i));
   always #2.5 clk_sys_i = ~clk_sys_i;
   always @(posedge clk_sys_i) begin
      cycles++;
      if (cycles == 3000) begin
         num_errors++;
         close_out();
      end
   end
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_compared++;
      if (got !== exp) begin
         $display("[ERR] %0t got %h exp %h", $time, got, exp);
         num_errors++;
      end
   endtask
   task automatic acc(input logic we, input xcc_addr_t a, input logic [3:0] be, input logic [31:0] d);
      @(posedge clk_sys_i);
      #1 cfg_req_i = 1;
      cfg_we_i = we;
      cfg_addr_i = a;
      cfg_be_i = be;
      cfg_wdata_i = d;
      @(posedge clk_sys_i);
      #1 cfg_req_i = 0;
      chk({31'h0, cfg_ack_o}, 32'h1);
   endtask
   task automatic wr(input xcc_addr_t a, input logic [3:0] be, input logic [31:0] d);
      acc(1, a, be, d);
   endtask
   task automatic rd(input xcc_addr_t a, input logic [31:0] exp);
      acc(0, a, 4'h0, 32'h0);
      chk(cfg_rdata_o, exp);
   endtask
   task automatic rst(input logic strap);
      #1 resetn_i = 0;
      acs_present_i = strap;
      repeat (10) @(posedge clk_sys_i);
      #1 resetn_i = 1;
      @(posedge clk_sys_i);
   endtask
   task automatic close_out();
      if (num_errors == 0 && n_compared > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask
   initial begin
      rst(1);
      rd(`XCC_OFF_MAKER_ID, {`XCC_DEVICE_ID, `XCC_MAKER_ID_RST});
      wr(`XCC_OFF_MAKER_ID, 4'hf, 32'h0000ffff);
      rd(`XCC_OFF_MAKER_ID, {`XCC_DEVICE_ID, `XCC_MAKER_ID_RST});
      @(posedge clk_sys_i);
      #1 id_load_i = 1;
      id_load_data_i = 16'h5a3c;
      @(posedge clk_sys_i);
      #1 id_load_i = 0;
      rd(`XCC_OFF_MAKER_ID, {`XCC_DEVICE_ID, 16'h5a3c});
      rd(`XCC_OFF_ERR_HDR, 32'h14010001);
      rd(`XCC_OFF_VC_HDR, 32'h20c10002);
      rd(`XCC_OFF_PWR_HDR, 32'h22010004);
      rd(`XCC_OFF_ACS_HDR, 32'h0001000d);
      rd(`XCC_OFF_LTR_HDR, 32'h00010018);
      rd(`XCC_OFF_VC_CAP1, 32'h00000001);
      rd(`XCC_OFF_CHANNEL_ZERO_RCAP, 32'h04000000);
      rd(`XCC_OFF_VC1_RCAP, 32'h06000000);
      rd(`XCC_OFF_CHANNEL_ZERO_RCTL, 32'h800000ff);
      wr(`XCC_OFF_CHANNEL_ZERO_RCTL, 4'hf, 32'h0);
      rd(`XCC_OFF_CHANNEL_ZERO_RCTL, 32'h0);
      wr(`XCC_OFF_VC1_RCTL, 4'hf, 32'hffffffff);
      rd(`XCC_OFF_VC1_RCTL, 32'h870000ff);
      rd(`XCC_OFF_VC1_RSTS, 32'h0);
      wr(`XCC_OFF_VC_CTLSTS, 4'hf, 32'hffffffff);
      rd(`XCC_OFF_VC_CTLSTS, 32'h0000000e);
      wr(`XCC_OFF_ARB_BASE, 4'hf, 32'ha5c3e17b);
      wr(`XCC_OFF_ARB_LAST, 4'hf, 32'h12345678);
      rd(`XCC_OFF_ARB_BASE, 32'ha5c3e17b);
      rd(`XCC_OFF_ARB_LAST, 32'h12345678);
      rd(12'h1c0, 32'h0);
      wr(`XCC_OFF_LTR_LIMITS, 4'hf, 32'hffffffff);
      rd(`XCC_OFF_LTR_LIMITS, 32'h1fff1fff);
      wr(`XCC_OFF_LTR_LIMITS, 4'h1, 32'h0);
      rd(`XCC_OFF_LTR_LIMITS, 32'h1fff1f00);
      wr(`XCC_OFF_ACS_CAPCTL, 4'hf, 32'hffffffff);
      rd(`XCC_OFF_ACS_CAPCTL, 32'h007f0000);
      wr(`XCC_OFF_EGRESS, 4'hf, 32'hffffffff);
      rd(`XCC_OFF_EGRESS, 32'h000000ff);
      rd(12'h300, 32'h0);
      rst(0);
      rd(`XCC_OFF_PWR_HDR, 32'h23010004);
      rd(`XCC_OFF_ACS_HDR, 32'h0);
      wr(`XCC_OFF_ACS_CAPCTL, 4'hf, 32'hffffffff);
      rd(`XCC_OFF_ACS_CAPCTL, 32'h0);
      wr(`XCC_OFF_EGRESS, 4'hf, 32'hffffffff);
      rd(`XCC_OFF_EGRESS, 32'h0);
      rd(`XCC_OFF_ARB_BASE, 32'h0);
      rd(`XCC_OFF_LTR_LIMITS, 32'h0);
      rd(`XCC_OFF_MAKER_ID, {`XCC_DEVICE_ID, `XCC_MAKER_ID_RST});
      close_out();
   end
endmodule
